// ==== hw/stcm_top.sv ====
// Top: torque command conditioning and dual control-mode switching.
// Assumes a classic Wishbone master on clk_i; digital inputs arrive asynchronously
// from the host controller; the analog input is an already digitised sample.
`timescale 1ns/1ps

// Functional notes
// - Torque mode command passes a first-order low-pass, constant 0 to 1000 ms.
// - Smoothing constant zero bypasses the filter and passes the command unchanged.
// - Torque percent equals input volts times full-scale setting over ten.
// - Full-scale setting accepts 0 to 1000 percent, resets to 100, all modes.
// - Position and speed modes scale the analog input into a torque limit.
// - Both selects off: zero command in zero-torque mode, analog otherwise.
// - Torque select inputs are honoured only after servo on.
// - Mode codes 06 to 10 give five dual modes, a digital input picks.
// - No zero-speed or zero-torque variants exist among the dual modes.
// - Speed/position switch on: speed mode, speed selects used, trigger ignored.
// - Switch off: position mode, motor held until a trigger rising edge.
// - Trigger rising edge latches the position select, or the pulse count in pulse mode, and moves there at once.
// - Speed/position switch on again returns to speed mode at once.
// - Pulse modes take position from pulses, preset modes from a stored table.
// - Speed/torque switch on: torque mode, torque selects used, speed selects ignored.
// - Speed/torque switch off selects speed command; on again returns to torque.
// - Torque/position switch on: position mode; pulse mode counts command pulses and follows them.
// - Torque/position switch off stops counting and drives the selected torque.
// - Torque/position switch on again returns to position mode at once.
// - Speed command is analog or one of three presets by speed selects.
// - Nonzero torque select picks one of three presets, each within 300 percent.
// - A new torque preset applies only after a torque select input changes.
module stcm_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic signed [15:0] analog_mv_i,
  input wire logic [1:0] torque_select_inputs_i,
  input wire logic [1:0] speed_select_inputs_i,
  input wire logic [2:0] position_select_inputs_i,
  input wire logic position_trigger_i,
  input wire logic mode_switch_i,
  input wire logic cmd_pulse_i,
  output logic [1:0] active_mode_o,
  output logic signed [15:0] torque_cmd_o,
  output logic signed [15:0] torque_limit_o,
  output logic torque_limit_valid_o,
  output logic signed [15:0] speed_cmd_o,
  output logic signed [31:0] position_target_o,
  output logic motor_hold_o,
  output logic position_from_pulse_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] smooth_q;
  logic [15:0] full_scale_q;
  logic [7:0] mode_q;
  logic [15:0] flags_q;
  logic signed [15:0] tq_preset_q [3];
  logic signed [15:0] sp_preset_q [3];
  logic signed [31:0] pos_preset_q [8];

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic trig_prev_q;
  logic pulse_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {torque_select_inputs_i, speed_select_inputs_i, position_select_inputs_i,
                 position_trigger_i, mode_switch_i, cmd_pulse_i};
      sync_q <= meta_q;
    end
  end

  logic [1:0] tsel;
  logic [1:0] ssel;
  logic [2:0] psel;
  logic trig;
  logic sw_on;
  logic pulse;
  assign tsel = sync_q[9:8];
  assign ssel = sync_q[7:6];
  assign psel = sync_q[5:3];
  assign trig = sync_q[2];
  assign sw_on = sync_q[1];
  assign pulse = sync_q[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev_q <= 1'b0;
      pulse_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig;
      pulse_prev_q <= pulse;
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic [11:0] idx;
  logic wr;
  logic [15:0] wdat;
  assign idx = wb_adr_i[13:2];
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign wdat = merge16(16'h0000, wb_dat_i[15:0], wb_sel_i[1:0]);

  // Partial writes keep untouched bytes, except torque and speed presets, whose unselected bytes clear
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
    clamp16 = (v > mx) ? mx : v;
  endfunction

  function automatic logic signed [15:0] clamp_pct(input logic signed [15:0] v);
    if (v > stcm_pkg::PRESET_TORQUE_MAX) begin
      clamp_pct = stcm_pkg::PRESET_TORQUE_MAX;
    end else if (v < -stcm_pkg::PRESET_TORQUE_MAX) begin
      clamp_pct = -stcm_pkg::PRESET_TORQUE_MAX;
    end else begin
      clamp_pct = v;
    end
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smooth_q <= stcm_pkg::SMOOTH_RESET;
      full_scale_q <= stcm_pkg::FULL_SCALE_RESET;
      mode_q <= stcm_pkg::MODE_RESET;
      flags_q <= stcm_pkg::FLAGS_RESET;
    end else if (wr) begin
      if (idx == stcm_pkg::TORQUE_SMOOTHING_CONSTANT_IDX) begin
        smooth_q <= clamp16(merge16(smooth_q, wb_dat_i[15:0], wb_sel_i[1:0]),
                            stcm_pkg::SMOOTH_MAX_MS);
      end
      if (idx == stcm_pkg::ANALOG_TORQUE_FULL_SCALE_IDX) begin
        full_scale_q <= clamp16(merge16(full_scale_q, wb_dat_i[15:0], wb_sel_i[1:0]),
                                stcm_pkg::FULL_SCALE_MAX);
      end
      // Only dual codes are accepted; anything else, incl. zero variants, is ignored
      if (idx == stcm_pkg::CONTROL_MODE_SETTING_IDX && wb_sel_i[0] &&
          wb_dat_i[7:0] >= stcm_pkg::MODE_PULSE_SPEED_DUAL &&
          wb_dat_i[7:0] <= stcm_pkg::MODE_SPEED_TORQUE_DUAL) begin
        mode_q <= wb_dat_i[7:0];
      end
      if (idx == stcm_pkg::CONTROL_FLAGS_IDX) begin
        flags_q <= merge16(flags_q, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        tq_preset_q[i] <= 16'sh0;
        sp_preset_q[i] <= 16'sh0;
      end
      for (int i = 0; i < 8; i++) begin
        pos_preset_q[i] <= 32'sh0;
      end
    end else if (wr) begin
      for (int i = 0; i < 3; i++) begin
        if (idx == stcm_pkg::TORQUE_PRESET_BASE_IDX + 12'(i)) begin
          tq_preset_q[i] <= clamp_pct(wdat);
        end
        if (idx == stcm_pkg::SPEED_PRESET_BASE_IDX + 12'(i)) begin
          sp_preset_q[i] <= wdat;
        end
      end
      for (int i = 0; i < 8; i++) begin
        if (idx == stcm_pkg::POSITION_PRESET_BASE_IDX + 12'(i)) begin
          pos_preset_q[i] <= merge32(pos_preset_q[i], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        old[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge32 = old;
  endfunction

  // ****************************************
  // Torque source and scaling
  // ****************************************
  logic signed [31:0] scaled;
  logic signed [15:0] analog_pct;
  logic [1:0] tsel_prev_q;
  logic signed [15:0] preset_sel_q;
  logic signed [15:0] tq_raw;
  logic signed [15:0] tq_smooth;
  logic servo_on;
  assign servo_on = flags_q[stcm_pkg::FLAG_SERVO_ON];

  // Input in millivolts: pct = mv * fs / 10000, i.e. volts * fs / 10
  assign scaled = (32'(analog_mv_i) * $signed({16'h0000, full_scale_q})) / 32'sd10000;
  assign analog_pct = scaled[15:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsel_prev_q <= 2'b00;
      preset_sel_q <= 16'sh0;
    end else begin
      tsel_prev_q <= tsel;
      // Preset latched only on a select change, so live edits wait for one
      if (tsel != tsel_prev_q && tsel != 2'b00) begin
        preset_sel_q <= tq_preset_q[tsel - 2'b01];
      end
    end
  end

  always_comb begin
    if (!servo_on || tsel == 2'b00) begin
      tq_raw = flags_q[stcm_pkg::FLAG_ZERO_TORQUE] ? 16'sh0 : analog_pct;
    end else begin
      tq_raw = preset_sel_q;
    end
  end

  stcm_smoother u_smooth (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tau_ms_i(smooth_q),
    .cmd_i(tq_raw),
    .cmd_o(tq_smooth)
  );

  // ****************************************
  // Mode switching
  // ****************************************
  stcm_pkg::stcm_active_t act;
  logic pulse_mode;
  logic hold_q;
  logic signed [31:0] pulse_cnt_q;

  assign pulse_mode = (mode_q == stcm_pkg::MODE_PULSE_SPEED_DUAL) ||
                      (mode_q == stcm_pkg::MODE_PULSE_TORQUE_DUAL);

  always_comb begin
    unique case (mode_q)
      stcm_pkg::MODE_PULSE_SPEED_DUAL, stcm_pkg::MODE_PRESET_SPEED_DUAL:
        act = sw_on ? stcm_pkg::STCM_ACT_SPEED : stcm_pkg::STCM_ACT_POSITION;
      stcm_pkg::MODE_PULSE_TORQUE_DUAL, stcm_pkg::MODE_PRESET_TORQUE_DUAL:
        act = sw_on ? stcm_pkg::STCM_ACT_POSITION : stcm_pkg::STCM_ACT_TORQUE;
      default:
        act = sw_on ? stcm_pkg::STCM_ACT_TORQUE : stcm_pkg::STCM_ACT_SPEED;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_cnt_q <= 32'sh0;
    end else if (act == stcm_pkg::STCM_ACT_POSITION && pulse_mode && pulse && !pulse_prev_q) begin
      pulse_cnt_q <= pulse_cnt_q + 32'sh1;
    end
  end

  logic speed_pos_dual;
  logic trig_rise;
  assign speed_pos_dual = (mode_q == stcm_pkg::MODE_PULSE_SPEED_DUAL) ||
                          (mode_q == stcm_pkg::MODE_PRESET_SPEED_DUAL);
  assign trig_rise = trig && !trig_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 1'b1;
      position_target_o <= 32'sh0;
    end else if (act != stcm_pkg::STCM_ACT_POSITION) begin
      hold_q <= 1'b1;
    end else if (speed_pos_dual && trig_rise) begin
      hold_q <= 1'b0;
      position_target_o <= pulse_mode ? pulse_cnt_q : pos_preset_q[psel];
    end else if (!speed_pos_dual) begin
      hold_q <= 1'b0;
      position_target_o <= pulse_mode ? pulse_cnt_q : pos_preset_q[psel];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_mode_o <= 2'b00;
      torque_cmd_o <= 16'sh0;
      torque_limit_o <= 16'sh0;
      torque_limit_valid_o <= 1'b0;
      speed_cmd_o <= 16'sh0;
      motor_hold_o <= 1'b1;
      position_from_pulse_o <= 1'b0;
    end else begin
      active_mode_o <= act;
      torque_cmd_o <= (act == stcm_pkg::STCM_ACT_TORQUE) ? tq_smooth : 16'sh0;
      torque_limit_o <= analog_pct;
      torque_limit_valid_o <= (act != stcm_pkg::STCM_ACT_TORQUE);
      // Speed selects ignored in torque mode; value frozen there
      if (act == stcm_pkg::STCM_ACT_SPEED) begin
        speed_cmd_o <= (ssel == 2'b00) ? analog_mv_i : sp_preset_q[ssel - 2'b01];
      end
      motor_hold_o <= (act == stcm_pkg::STCM_ACT_POSITION) && hold_q && speed_pos_dual;
      position_from_pulse_o <= pulse_mode;
    end
  end

  logic [15:0] rd16;
  always_comb begin
    rd16 = 16'h0000;
    if (idx == stcm_pkg::TORQUE_SMOOTHING_CONSTANT_IDX) rd16 = smooth_q;
    if (idx == stcm_pkg::ANALOG_TORQUE_FULL_SCALE_IDX) rd16 = full_scale_q;
    if (idx == stcm_pkg::CONTROL_MODE_SETTING_IDX) rd16 = {8'h00, mode_q};
    if (idx == stcm_pkg::CONTROL_FLAGS_IDX) rd16 = flags_q;
    if (idx == stcm_pkg::STATUS_IDX) rd16 = {13'h0000, motor_hold_o, active_mode_o};
    if (idx == stcm_pkg::TORQUE_OUT_IDX) rd16 = torque_cmd_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= (idx == stcm_pkg::PULSE_COUNT_IDX) ? pulse_cnt_q : {16'h0000, rd16};
    end
  end

endmodule // stcm_top

// ==== hw/stcm_pkg.sv ====
// Package: constants for torque command conditioning and dual mode selection.
// Assumes a 100 MHz control clock and a classic Wishbone register bus.
package stcm_pkg;

  // ****************************************
  // Register map (printed offsets are word indices)
  // ****************************************
  localparam logic [11:0] TORQUE_SMOOTHING_CONSTANT_IDX = 12'h107;
  localparam logic [11:0] ANALOG_TORQUE_FULL_SCALE_IDX = 12'h129;
  localparam logic [11:0] CONTROL_MODE_SETTING_IDX = 12'h101;
  localparam logic [11:0] CONTROL_FLAGS_IDX = 12'h200;
  localparam logic [11:0] TORQUE_PRESET_BASE_IDX = 12'h10c;
  localparam logic [11:0] SPEED_PRESET_BASE_IDX = 12'h109;
  localparam logic [11:0] POSITION_PRESET_BASE_IDX = 12'h10f;
  localparam logic [11:0] STATUS_IDX = 12'h300;
  localparam logic [11:0] TORQUE_OUT_IDX = 12'h301;
  localparam logic [11:0] PULSE_COUNT_IDX = 12'h302;

  // ****************************************
  // Reset values and ranges
  // ****************************************
  localparam logic [15:0] SMOOTH_RESET = 16'h0000;
  localparam logic [15:0] FULL_SCALE_RESET = 16'h0064;
  localparam logic [15:0] SMOOTH_MAX_MS = 16'h03e8;
  localparam logic [15:0] FULL_SCALE_MAX = 16'h03e8;
  localparam logic signed [15:0] PRESET_TORQUE_MAX = 16'sh012c;
  localparam logic [7:0] MODE_RESET = 8'h0a;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam int FLAG_SERVO_ON = 0;
  localparam int FLAG_ZERO_TORQUE = 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_SEC = 1000;
  localparam int TICK_MS = 1;
  localparam logic [16:0] CYCLES_PER_MS = 17'(CLK_HZ / MS_PER_SEC * TICK_MS);

  // ****************************************
  // Control modes
  // ****************************************
  localparam logic [7:0] MODE_PULSE_SPEED_DUAL = 8'h06;
  localparam logic [7:0] MODE_PULSE_TORQUE_DUAL = 8'h07;
  localparam logic [7:0] MODE_PRESET_SPEED_DUAL = 8'h08;
  localparam logic [7:0] MODE_PRESET_TORQUE_DUAL = 8'h09;
  localparam logic [7:0] MODE_SPEED_TORQUE_DUAL = 8'h0a;

  typedef enum logic [1:0] {
    STCM_ACT_POSITION,
    STCM_ACT_SPEED,
    STCM_ACT_TORQUE
  } stcm_active_t;

endpackage

// ==== hw/stcm_smoother.sv ====
// First-order low-pass on the torque command, one update per millisecond.
// Assumes a signed command in rated-torque percent from the same clock domain.
`timescale 1ns/1ps
module stcm_smoother (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] tau_ms_i,
  input wire logic signed [15:0] cmd_i,
  output logic signed [15:0] cmd_o
);

  logic [16:0] tick_cnt_q;
  logic tick;
  logic signed [31:0] acc_q;
  logic signed [31:0] err;
  logic signed [31:0] step;
  logic [15:0] tau_cl;

  // Clamp keeps the divide bounded to the documented range
  assign tau_cl = (tau_ms_i > stcm_pkg::SMOOTH_MAX_MS) ? stcm_pkg::SMOOTH_MAX_MS : tau_ms_i;
  assign tick = (tick_cnt_q == stcm_pkg::CYCLES_PER_MS - 17'h00001);
  assign err = ($signed({{16{cmd_i[15]}}, cmd_i}) <<< 16) - acc_q;
  // Step of err/(tau+1) per ms approximates exp(-t/tau); tau 0 never reaches here
  assign step = err / $signed({16'h0000, tau_cl + 16'h0001});

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_q <= 17'h00000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= 32'sh0;
    end else if (tau_cl == 16'h0000) begin
      acc_q <= $signed({cmd_i, 16'h0000});
    end else if (tick) begin
      acc_q <= acc_q + step;
    end
  end

  // Bypass path is combinational so a zero constant adds no lag
  assign cmd_o = (tau_cl == 16'h0000) ? cmd_i : acc_q[31:16];

endmodule // stcm_smoother

// ==== verification/stcm_asserts.sv ====
// Checker: bus handshake and mode output relations of stcm_top.
// Assumes it is bound onto stcm_top and sees its ports only.
`timescale 1ns/1ps
module stcm_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [1:0] active_mode_o,
  input wire logic signed [15:0] torque_cmd_o,
  input wire logic torque_limit_valid_o,
  input wire logic motor_hold_o,
  input wire logic position_trigger_i
);
  logic [2:0] settle_q;
  // Outputs lag reset release through the input synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_q <= 3'h0;
    end else if (settle_q != 3'h7) begin
      settle_q <= settle_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ****
  // Properties
  // ****
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_not_torque;
    (settle_q == 3'h7 && active_mode_o != 2'h2) [*3];
  endsequence
  sequence s_steady;
    (settle_q == 3'h7 && $stable(active_mode_o)) [*2];
  endsequence
  property p_ack_req;
    s_req |=> s_ack;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack late or long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_idle;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack while idle");
  property p_mode_legal;
    active_mode_o != 2'h3;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("bad active mode");
  property p_tq_zero;
    s_not_torque |-> torque_cmd_o == 16'sh0000;
  endproperty
  a_tq_zero: assert property (p_tq_zero) else $error("torque outside torque mode");
  property p_lim_valid;
    s_steady |-> torque_limit_valid_o == (active_mode_o != 2'h2);
  endproperty
  a_lim_valid: assert property (p_lim_valid) else $error("limit valid wrong");
  property p_tq_range;
    torque_cmd_o <= 16'sh03e8 && torque_cmd_o >= -16'sh03e8;
  endproperty
  a_tq_range: assert property (p_tq_range) else $error("torque out of range");
  property p_hold_go;
    settle_q == 3'h7 && active_mode_o == 2'h0 && motor_hold_o && $rose(position_trigger_i)
      |-> ##[2:6] !motor_hold_o;
  endproperty
  a_hold_go: assert property (p_hold_go) else $error("hold kept after trigger");
endmodule // stcm_asserts

bind stcm_top stcm_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .active_mode_o, .torque_cmd_o, .torque_limit_valid_o, .motor_hold_o, .position_trigger_i);

// ==== verification/stcm_host.sv ====
// Host model: contact inputs and a command pulse train.
// Assumes the bench sets the contact word and pulse enable after clock edges.
`timescale 1ns/1ps
module stcm_host (
  input wire logic clk_i,
  input wire logic [8:0] contact_i,
  input wire logic pulse_en_i,
  output logic [1:0] tsel_o,
  output logic [1:0] ssel_o,
  output logic [2:0] psel_o,
  output logic trig_o,
  output logic switch_o,
  output logic pulse_o
);
  logic [1:0] phase_q;
  initial begin
    {switch_o, trig_o, psel_o, ssel_o, tsel_o} = 9'h000;
    phase_q = 2'h0;
  end
  // Closed contact reads one, open contact zero
  always @(posedge clk_i) begin
    {switch_o, trig_o, psel_o, ssel_o, tsel_o} <= contact_i;
  end
  // Two high, two low: slow enough for the synchronisers
  always @(posedge clk_i) begin
    phase_q <= pulse_en_i ? phase_q + 2'h1 : 2'h0;
  end
  assign pulse_o = phase_q[1];
endmodule // stcm_host

// ==== verification/tb.sv ====
// Bench: registers, mode switching and torque scaling of stcm_top.
// Assumes stcm_host drives contacts and pulses; 100 MHz clock.
`timescale 1ns/1ps
module tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_pulse_i, pen;
  logic [13:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
  logic signed [15:0] analog_mv_i, torque_cmd_o, torque_limit_o, speed_cmd_o;
  logic [1:0] torque_select_inputs_i, speed_select_inputs_i, active_mode_o;
  logic [2:0] position_select_inputs_i;
  logic position_trigger_i, mode_switch_i, torque_limit_valid_o, motor_hold_o;
  logic position_from_pulse_o;
  logic signed [31:0] position_target_o;
  logic [8:0] con;
  int err_count, compares;
  stcm_host u_host (.clk_i, .contact_i(con), .pulse_en_i(pen), .tsel_o(torque_select_inputs_i),
    .ssel_o(speed_select_inputs_i), .psel_o(position_select_inputs_i),
    .trig_o(position_trigger_i), .switch_o(mode_switch_i), .pulse_o(cmd_pulse_i));
  stcm_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .analog_mv_i, .torque_select_inputs_i, .speed_select_inputs_i,
    .position_select_inputs_i, .position_trigger_i, .mode_switch_i, .cmd_pulse_i,
    .active_mode_o, .torque_cmd_o, .torque_limit_o, .torque_limit_valid_o, .speed_cmd_o,
    .position_target_o, .motor_hold_o, .position_from_pulse_o);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_tq(input int v, input int f);
    return 32'(v * f / 10000);
  endfunction
  function automatic logic [31:0] exp_clamp(input int p);
    return 32'((p > 300) ? 300 : ((p < -300) ? -300 : p));
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= d;
    // No cycle count assumed: a lost ack is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] idx, input logic [31:0] e);
    wb(1'b0, idx, 32'h0);
    chk(nm, e, rd);
  endtask
  // Contact word: switch, trigger, position, speed, torque selects
  task automatic pins(input logic [8:0] c);
    con <= c;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pulses();
    pen <= 1'b1;
    repeat (16) @(posedge clk_i);
    pen <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    int v, f;
    logic [31:0] c0;
    logic signed [15:0] tp [3];
    seed = 32'h0000003a;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pen} = 5'h10;
    wb_adr_i = 14'h0000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    analog_mv_i = 16'sh0000;
    con = 9'h000;
    err_count = 0;
    compares = 0;
    tp = '{16'sh0078, -16'sh00fa, 16'sh0190};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("smooth", stcm_pkg::TORQUE_SMOOTHING_CONSTANT_IDX, 32'h0);
    rdchk("full_scale", stcm_pkg::ANALOG_TORQUE_FULL_SCALE_IDX, 32'h64);
    rdchk("unmapped", 12'h3ff, 32'h0);
    wb(1'b1, stcm_pkg::TORQUE_SMOOTHING_CONSTANT_IDX, 32'h7d0);
    rdchk("smooth_max", stcm_pkg::TORQUE_SMOOTHING_CONSTANT_IDX, 32'h3e8);
    wb(1'b1, stcm_pkg::ANALOG_TORQUE_FULL_SCALE_IDX, 32'h3e9);
    rdchk("fs_max", stcm_pkg::ANALOG_TORQUE_FULL_SCALE_IDX, 32'h3e8);
    for (int m = 5; m < 12; m++) begin
      wb(1'b1, stcm_pkg::CONTROL_MODE_SETTING_IDX, 32'(m));
      c0 = (m inside {[6:10]}) ? 32'(m) : 32'h0a;
      rdchk("mode_code", stcm_pkg::CONTROL_MODE_SETTING_IDX, c0);
    end
    wb(1'b1, stcm_pkg::TORQUE_SMOOTHING_CONSTANT_IDX, 32'h0);
    wb(1'b1, stcm_pkg::CONTROL_FLAGS_IDX, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? -10000 : (int'(rnd() % 201) - 100) * 100;
      f = (i == 0) ? 1000 : int'(rnd() % 11) * 100;
      wb(1'b1, stcm_pkg::ANALOG_TORQUE_FULL_SCALE_IDX, 32'(f));
      analog_mv_i <= 16'(v);
      pins(9'h100);
      chk("mode_t", 32'h2, 32'(active_mode_o));
      chk("torque_cmd", exp_tq(v, f), 32'(torque_cmd_o));
      pins(9'h000);
      chk("mode_s", 32'h1, 32'(active_mode_o));
      chk("torque_limit", exp_tq(v, f), 32'(torque_limit_o));
      chk("limit_valid", 32'h1, 32'(torque_limit_valid_o));
      chk("speed_analog", 32'(v), 32'(speed_cmd_o));
    end
    $display("test scaling done");
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, stcm_pkg::TORQUE_PRESET_BASE_IDX + 12'(k), 32'(tp[k]));
      wb(1'b1, stcm_pkg::SPEED_PRESET_BASE_IDX + 12'(k), 32'(k * 1000 + 500));
    end
    for (int k = 0; k < 3; k++) begin
      pins({1'b1, 6'h00, 2'(k + 1)});
      chk("torque_preset", exp_clamp(int'(tp[k])), 32'(torque_cmd_o));
      pins({5'h00, 2'(k + 1), 2'h0});
      chk("speed_preset", 32'(k * 1000 + 500), 32'(speed_cmd_o));
    end
    pins(9'h101);
    wb(1'b1, stcm_pkg::TORQUE_PRESET_BASE_IDX, 32'h32);
    pins(9'h101);
    chk("preset_held", 32'h78, 32'(torque_cmd_o));
    pins(9'h102);
    pins(9'h101);
    chk("preset_new", 32'h32, 32'(torque_cmd_o));
    wb(1'b1, stcm_pkg::ANALOG_TORQUE_FULL_SCALE_IDX, 32'h64);
    analog_mv_i <= 16'sh1388;
    wb(1'b1, stcm_pkg::CONTROL_FLAGS_IDX, 32'h3);
    pins(9'h100);
    chk("zero_torque", 32'h0, 32'(torque_cmd_o));
    wb(1'b1, stcm_pkg::CONTROL_FLAGS_IDX, 32'h1);
    pins(9'h100);
    chk("analog_torque", 32'h32, 32'(torque_cmd_o));
    wb(1'b1, stcm_pkg::CONTROL_FLAGS_IDX, 32'h0);
    pins(9'h102);
    chk("servo_off", 32'h32, 32'(torque_cmd_o));
    $display("test presets done");
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, stcm_pkg::POSITION_PRESET_BASE_IDX + 12'(k), 32'(k * 1000 + 7));
    end
    wb(1'b1, stcm_pkg::CONTROL_MODE_SETTING_IDX, 32'h08);
    // Trigger raised in speed mode must not count as a later edge
    pins(9'h1a0);
    chk("mode_s_pr", 32'h1, 32'(active_mode_o));
    chk("src_table", 32'h0, 32'(position_from_pulse_o));
    pins(9'h0a0);
    chk("mode_p_pr", 32'h0, 32'(active_mode_o));
    chk("hold_wait", 32'h1, 32'(motor_hold_o));
    pins(9'h050);
    pins(9'h0d0);
    chk("hold_done", 32'h0, 32'(motor_hold_o));
    chk("target", 32'h138f, 32'(position_target_o));
    pins(9'h100);
    chk("mode_back_s", 32'h1, 32'(active_mode_o));
    wb(1'b1, stcm_pkg::CONTROL_MODE_SETTING_IDX, 32'h07);
    pins(9'h100);
    chk("mode_p_pt", 32'h0, 32'(active_mode_o));
    chk("src_pulse", 32'h1, 32'(position_from_pulse_o));
    wb(1'b0, stcm_pkg::PULSE_COUNT_IDX, 32'h0);
    c0 = rd + 32'h4;
    pulses();
    rdchk("pulse_count", stcm_pkg::PULSE_COUNT_IDX, c0);
    chk("pulse_target", c0, 32'(position_target_o));
    pins(9'h000);
    chk("mode_t_pt", 32'h2, 32'(active_mode_o));
    chk("torque_pt", 32'h32, 32'(torque_cmd_o));
    pulses();
    rdchk("pulse_frozen", stcm_pkg::PULSE_COUNT_IDX, c0);
    pins(9'h100);
    chk("mode_back_p", 32'h0, 32'(active_mode_o));
    wb(1'b1, stcm_pkg::CONTROL_MODE_SETTING_IDX, 32'h09);
    pins(9'h130);
    chk("target_pr_t", 32'hbbf, 32'(position_target_o));
    wb(1'b1, stcm_pkg::CONTROL_MODE_SETTING_IDX, 32'h0a);
    pins(9'h100);
    wb(1'b1, stcm_pkg::TORQUE_SMOOTHING_CONSTANT_IDX, 32'ha);
    analog_mv_i <= 16'sh2710;
    pins(9'h100);
    chk("smoothed", 32'h1, 32'(torque_cmd_o < 16'sh0064));
    $display("test modes done");
    summarize();
  end
endmodule // tb
